// ===== logic/scnif_pkg.sv
package scnif_pkg;
  // byte addresses on the register bus
  localparam logic [3:0] OFS_CONTROL_ONE = 4'h0;
  localparam logic [3:0] OFS_CONTROL_TWO = 4'h4;
  localparam logic [3:0] OFS_CONTROL_THREE = 4'h8;

  localparam logic [15:0] RST_CONTROL_ONE = 16'h0000;
  localparam logic [15:0] RST_CONTROL_TWO = 16'h0000;
  localparam logic [15:0] RST_CONTROL_THREE = 16'h0000;
  localparam logic [31:0] RST_READ_DATA = 32'h00000000;
  localparam logic [6:0] RST_FLAGS = 7'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;

  // control one fields
  localparam int BIT_UNIT_ENABLE = 0;
  localparam int BIT_TEST_CYCLE = 1;
  localparam int FLAG_LSB = 2;
  localparam int FLAG_MSB = 8;
  localparam int ENABLE_LSB = 9;
  localparam int ENABLE_MSB = 15;
  localparam int FLAG_COUNT = 7;

  // flag index inside the flag bank
  localparam int FLG_OUTPUT = 0;
  localparam int FLG_STOP = 1;
  localparam int FLG_START = 2;
  localparam int FLG_COUNT_ONE = 3;
  localparam int FLG_COUNT_TWO = 4;
  localparam int FLG_STATE_Q6 = 5;
  localparam int FLG_STATE_Q7 = 6;

  // control two fields
  localparam int BIT_DAC_FORCE = 15;
  localparam int BIT_COMP_FORCE = 14;
  localparam int BIT_COMP_INVERT = 13;
  localparam int BIT_GROUP_SELECT = 12;
  localparam int BIT_COMMON_SELECT = 11;
  localparam int BIT_FOURTH_SELECT = 10;
  localparam int BIT_GROUND_SELECT = 9;
  localparam int BIT_MID_VOLTAGE = 8;
  localparam int BIT_SAMPLE_HOLD = 7;
  localparam int BIT_EXCITATION = 6;
  localparam int TCH_ONE_LSB = 4;
  localparam int TCH_ZERO_LSB = 2;
  localparam int BIT_RESULT_ONE = 1;
  localparam int BIT_RESULT_ZERO = 0;
  localparam logic [15:0] CONTROL_TWO_WRITE_MASK = 16'hFFFC;

  // control three fields
  localparam int CNT_TWO_SRC_LSB = 10;
  localparam int CNT_ONE_SRC_LSB = 8;
  localparam int OUT_SRC_LSB = 4;
  localparam logic [15:0] CONTROL_THREE_WRITE_MASK = 16'h0F70;

  // counter flag source encodings
  localparam logic [1:0] SRC_EACH_COUNT = 2'h0;
  localparam logic [1:0] SRC_MODULO_4 = 2'h1;
  localparam logic [1:0] SRC_MODULO_64 = 2'h2;
  localparam logic [1:0] SRC_WRAP = 2'h3;
  localparam logic [7:0] COUNT_ONE_TOP = 8'hFF;
  localparam logic [7:0] COUNT_TWO_LAST = 8'h01;
endpackage

// ===== logic/scnif_flag_if.sv
`timescale 1ns/100ps
`default_nettype none
interface scnif_flag_if;
  logic [6:0] set;
  logic [6:0] wr;
  logic [6:0] wdata;
  logic [6:0] flags;
  modport ctrl (output set, output wr, output wdata, input flags);
  modport bank (input set, input wr, input wdata, output flags);
endinterface
`default_nettype wire

// ===== logic/scnif_sync.sv
`timescale 1ns/100ps
`default_nettype none
module scnif_sync #(
  parameter int WIDTH = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage;

  // first stage feeds only the second one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage <= '0;
      q <= '0;
    end else if (ce) begin
      stage <= d;
      q <= stage;
    end
  end
endmodule
`default_nettype wire

// ===== logic/scnif_flags.sv
`timescale 1ns/100ps
`default_nettype none
module scnif_flags
  import scnif_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  scnif_flag_if.bank fb
);
  genvar i;
  generate
    for (i = 0; i < FLAG_COUNT; i++) begin : g_flag
      // hardware set wins over a software clear in the same cycle
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          fb.flags[i] <= RST_FLAGS[i];
        end else if (ce) begin
          fb.flags[i] <= fb.set[i] | (fb.wr[i] ? fb.wdata[i] : fb.flags[i]);
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== logic/scnif_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - counter two condition sets its sticky flag
// - counter one condition sets its sticky flag
// - sequence start sets sticky start flag
// - stop signal rising edge sets stop flag
// - chosen front-end output condition sets flag
// - flags read pending; only software clears them
// - test cycle bit self-clears when cycle ends
// - unit enable bit gates event flag setting and drives scan unit enable
// - dac force holds dac enable on
// - comparator force holds comparator enable on
// - invert bit inverts comparator output
// - group bit picks sensor or comparator inputs
// - common select picks single common input when the group bit is set
// - fourth-input bit forces comparator input three when group bit set and common select clear
// - ground select zero holds ground switch closed
// - mid voltage on only without sample-hold
// - sample-hold bit drives sample-hold enable
// - excitation bit drives excitation enable
// - test channel one field picks input
// - test channel zero field picks input
// - read-only latest results per test channel
// - interrupt request per enabled pending flag
module scnif_ctrl
  import scnif_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [7:0] FIRST_EVENT_COUNTER,
  input wire logic FIRST_COUNTER_STEP,
  input wire logic [7:0] SECOND_EVENT_COUNTER,
  input wire logic SECOND_COUNTER_STEP,
  input wire logic SEQUENCE_START,
  input wire logic SEQUENCER_STOP_SIGNAL,
  input wire logic STATE_Q6_ENTRY,
  input wire logic STATE_Q7_ENTRY,
  input wire logic TEST_CYCLE_DONE,
  input wire logic SEQ_DAC_REQUEST,
  input wire logic SEQ_COMP_REQUEST,
  input wire logic SEQ_GROUND_REQUEST,
  input wire logic [1:0] SEQ_CHANNEL_SELECT,
  input wire logic SEQ_TEST_ACTIVE,
  input wire logic SEQ_TEST_CHANNEL,
  input wire logic SEQ_RESULT_STROBE,
  input wire logic [3:0] FRONT_END_OUTPUT_BITS,
  input wire logic COMPARATOR_RAW,
  output logic SCAN_UNIT_ENABLE,
  output logic TEST_CYCLE_REQUEST,
  output logic [6:0] EVENT_IRQ,
  output logic DAC_ENABLE,
  output logic COMPARATOR_ENABLE,
  output logic COMPARATOR_OUT,
  output logic COMP_GROUP_SELECT,
  output logic COMP_COMMON_INPUT,
  output logic [1:0] COMP_INPUT_INDEX,
  output logic SAMPLE_GROUND_CONNECT,
  output logic MID_VOLTAGE_ENABLE,
  output logic SAMPLE_HOLD_ENABLE,
  output logic EXCITATION_ENABLE
);
  scnif_flag_if fbus ();

  logic ack, req, wr_go;
  logic sel_one, sel_two, sel_three;
  logic [15:0] ctl_one, ctl_two, ctl_three;
  logic [15:2] ctl_two_store;
  logic [15:0] lane_mask;
  logic [15:0] merged_one, merged_two;
  logic [6:0] irq_enable;
  logic unit_enable;
  logic test_request;
  logic result_one, result_zero;
  logic [4:0] pin_sync;
  logic [3:0] fe_bits;
  logic [3:0] fe_last;
  logic comp_sync;
  logic comp_val;
  logic stop_last;
  logic [7:0] count_one_prev, count_two_prev;
  logic hit_one, hit_two, hit_out;
  logic [1:0] out_sel;
  logic out_want;
  logic [1:0] chan_index;
  logic [15:0] next_read;

  // front-end pins come from the analog side and need two stages
  scnif_sync #(.WIDTH(5)) u_pin_sync (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(CE),
    .d({COMPARATOR_RAW, FRONT_END_OUTPUT_BITS}),
    .q(pin_sync)
  );

  scnif_flags u_flags (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(CE),
    .fb(fbus.bank)
  );

  assign fe_bits = pin_sync[3:0];
  assign comp_sync = pin_sync[4];

  // bus slave: one wait cycle, answer on the second edge
  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack;
  assign wr_go = AVS_WRITE & ack;
  assign lane_mask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  always_comb begin
    sel_one = 1'b0;
    sel_two = 1'b0;
    sel_three = 1'b0;
    if (AVS_ADDRESS == OFS_CONTROL_ONE) begin
      sel_one = 1'b1;
    end else if (AVS_ADDRESS == OFS_CONTROL_TWO) begin
      sel_two = 1'b1;
    end else if (AVS_ADDRESS == OFS_CONTROL_THREE) begin
      sel_three = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ack <= 1'b0;
    end else if (CE) begin
      ack <= req & ~ack;
    end
  end

  always_comb begin
    next_read = 16'h0000;
    if (sel_one) begin
      next_read = ctl_one;
    end else if (sel_two) begin
      next_read = ctl_two;
    end else if (sel_three) begin
      next_read = ctl_three;
    end
  end

  // read data are captured in the wait cycle so they stand at the answer edge
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      AVS_READDATA <= RST_READ_DATA;
    end else if (CE && AVS_READ && !ack) begin
      AVS_READDATA <= {16'h0000, next_read};
    end
  end

  // control one image
  always_comb begin
    ctl_one = 16'h0000;
    ctl_one[ENABLE_MSB:ENABLE_LSB] = irq_enable;
    ctl_one[FLAG_MSB:FLAG_LSB] = fbus.flags;
    ctl_one[BIT_TEST_CYCLE] = test_request;
    ctl_one[BIT_UNIT_ENABLE] = unit_enable;
  end

  assign merged_one = (AVS_WRITEDATA[15:0] & lane_mask) | (ctl_one & ~lane_mask);

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      irq_enable <= RST_CONTROL_ONE[ENABLE_MSB:ENABLE_LSB];
      unit_enable <= RST_CONTROL_ONE[BIT_UNIT_ENABLE];
    end else if (CE && wr_go && sel_one) begin
      irq_enable <= merged_one[ENABLE_MSB:ENABLE_LSB];
      unit_enable <= merged_one[BIT_UNIT_ENABLE];
    end
  end

  // a fresh request written in the done cycle is kept, not lost
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      test_request <= RST_CONTROL_ONE[BIT_TEST_CYCLE];
    end else if (CE) begin
      if (wr_go && sel_one) begin
        test_request <= merged_one[BIT_TEST_CYCLE];
      end else if (TEST_CYCLE_DONE) begin
        test_request <= 1'b0;
      end
    end
  end

  // software write path into the flag bank, one write strobe per flag, taken from its byte lane
  assign fbus.wdata = merged_one[FLAG_MSB:FLAG_LSB];
  assign fbus.wr = (wr_go && sel_one) ?
    {AVS_BYTEENABLE[1], {6{AVS_BYTEENABLE[0]}}} : 7'h00;

  // control two and three storage
  assign merged_two = (AVS_WRITEDATA[15:0] & lane_mask & CONTROL_TWO_WRITE_MASK)
    | (ctl_two & ~(lane_mask & CONTROL_TWO_WRITE_MASK));
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ctl_two_store <= RST_CONTROL_TWO[15:2];
    end else if (CE && wr_go && sel_two) begin
      ctl_two_store <= merged_two[15:2];
    end
  end
  assign ctl_two = {ctl_two_store, result_one, result_zero};

  logic [15:0] ctl_three_store;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ctl_three_store <= RST_CONTROL_THREE;
    end else if (CE && wr_go && sel_three) begin
      ctl_three_store <= (AVS_WRITEDATA[15:0] & lane_mask & CONTROL_THREE_WRITE_MASK)
        | (ctl_three_store & ~(lane_mask & CONTROL_THREE_WRITE_MASK));
    end
  end

  assign ctl_three = {ctl_three_store[15:4], fe_bits};

  // event detection; a disabled unit raises no events
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      stop_last <= 1'b0;
      fe_last <= 4'h0;
    end else if (CE) begin
      stop_last <= SEQUENCER_STOP_SIGNAL;
      fe_last <= fe_bits;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      count_one_prev <= RST_COUNT;
      count_two_prev <= RST_COUNT;
    end else if (CE) begin
      if (FIRST_COUNTER_STEP) begin
        count_one_prev <= FIRST_EVENT_COUNTER;
      end
      if (SECOND_COUNTER_STEP) begin
        count_two_prev <= SECOND_EVENT_COUNTER;
      end
    end
  end

  always_comb begin
    hit_one = 1'b0;
    case (ctl_three[CNT_ONE_SRC_LSB +: 2])
      SRC_EACH_COUNT: hit_one = 1'b1;
      SRC_MODULO_4: hit_one = (FIRST_EVENT_COUNTER[1:0] == 2'h0);
      SRC_MODULO_64: hit_one = (FIRST_EVENT_COUNTER[5:0] == 6'h00);
      default: hit_one = (FIRST_EVENT_COUNTER == 8'h00) && (count_one_prev == COUNT_ONE_TOP);
    endcase
    hit_one = hit_one & FIRST_COUNTER_STEP;
  end

  always_comb begin
    hit_two = 1'b0;
    case (ctl_three[CNT_TWO_SRC_LSB +: 2])
      SRC_EACH_COUNT: hit_two = 1'b1;
      SRC_MODULO_4: hit_two = (SECOND_EVENT_COUNTER[1:0] == 2'h0);
      SRC_MODULO_64: hit_two = (SECOND_EVENT_COUNTER[5:0] == 6'h00);
      default: hit_two = (SECOND_EVENT_COUNTER == 8'h00) && (count_two_prev == COUNT_TWO_LAST);
    endcase
    hit_two = hit_two & SECOND_COUNTER_STEP;
  end

  // output condition fires on the transition into the chosen level
  assign out_sel = ctl_three[OUT_SRC_LSB+1 +: 2];
  assign out_want = ~ctl_three[OUT_SRC_LSB];
  assign hit_out = (fe_bits[out_sel] == out_want) && (fe_last[out_sel] != out_want);

  always_comb begin
    fbus.set = 7'h00;
    if (unit_enable) begin
      fbus.set[FLG_OUTPUT] = hit_out;
      fbus.set[FLG_STOP] = SEQUENCER_STOP_SIGNAL & ~stop_last;
      fbus.set[FLG_START] = SEQUENCE_START;
      fbus.set[FLG_COUNT_ONE] = hit_one;
      fbus.set[FLG_COUNT_TWO] = hit_two;
      fbus.set[FLG_STATE_Q6] = STATE_Q6_ENTRY;
      fbus.set[FLG_STATE_Q7] = STATE_Q7_ENTRY;
    end
  end

  // comparator path and test channel results
  assign comp_val = comp_sync ^ ctl_two[BIT_COMP_INVERT];

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      result_one <= 1'b0;
      result_zero <= 1'b0;
    end else if (CE && SEQ_RESULT_STROBE) begin
      if (SEQ_TEST_CHANNEL) begin
        result_one <= comp_val;
      end else begin
        result_zero <= comp_val;
      end
    end
  end

  // during a test cycle the test channel fields replace the channel select logic
  always_comb begin
    chan_index = SEQ_CHANNEL_SELECT;
    if (SEQ_TEST_ACTIVE) begin
      if (SEQ_TEST_CHANNEL) begin
        chan_index = ctl_two[TCH_ONE_LSB +: 2];
      end else begin
        chan_index = ctl_two[TCH_ZERO_LSB +: 2];
      end
    end
  end

  // all analog controls leave from flip-flops, one cycle after their cause
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      COMP_GROUP_SELECT <= 1'b0;
      COMP_COMMON_INPUT <= 1'b0;
      COMP_INPUT_INDEX <= 2'h0;
    end else if (CE) begin
      COMP_GROUP_SELECT <= ctl_two[BIT_GROUP_SELECT];
      COMP_COMMON_INPUT <= ctl_two[BIT_GROUP_SELECT] & ctl_two[BIT_COMMON_SELECT];
      if (ctl_two[BIT_GROUP_SELECT] && !ctl_two[BIT_COMMON_SELECT] && ctl_two[BIT_FOURTH_SELECT]) begin
        COMP_INPUT_INDEX <= 2'h3;
      end else begin
        COMP_INPUT_INDEX <= chan_index;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      DAC_ENABLE <= 1'b0;
      COMPARATOR_ENABLE <= 1'b0;
      COMPARATOR_OUT <= 1'b0;
      SAMPLE_GROUND_CONNECT <= 1'b0;
      MID_VOLTAGE_ENABLE <= 1'b0;
      SAMPLE_HOLD_ENABLE <= 1'b0;
      EXCITATION_ENABLE <= 1'b0;
    end else if (CE) begin
      DAC_ENABLE <= ctl_two[BIT_DAC_FORCE] | SEQ_DAC_REQUEST;
      COMPARATOR_ENABLE <= ctl_two[BIT_COMP_FORCE] | SEQ_COMP_REQUEST;
      COMPARATOR_OUT <= comp_val;
      SAMPLE_GROUND_CONNECT <= ~ctl_two[BIT_GROUND_SELECT] | SEQ_GROUND_REQUEST;
      MID_VOLTAGE_ENABLE <= ctl_two[BIT_MID_VOLTAGE] & ~ctl_two[BIT_SAMPLE_HOLD];
      SAMPLE_HOLD_ENABLE <= ctl_two[BIT_SAMPLE_HOLD];
      EXCITATION_ENABLE <= ctl_two[BIT_EXCITATION];
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      SCAN_UNIT_ENABLE <= 1'b0;
      TEST_CYCLE_REQUEST <= 1'b0;
      EVENT_IRQ <= 7'h00;
    end else if (CE) begin
      SCAN_UNIT_ENABLE <= unit_enable;
      TEST_CYCLE_REQUEST <= test_request;
      EVENT_IRQ <= fbus.flags & irq_enable;
    end
  end
endmodule
`default_nettype wire

// ===== verification/scnif_ctrl_properties.sv
`timescale 1ns/100ps
`default_nettype none
module scnif_chk
  import scnif_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic AVS_WAITREQUEST,
  input wire logic TEST_CYCLE_DONE,
  input wire logic TEST_CYCLE_REQUEST,
  input wire logic SCAN_UNIT_ENABLE,
  input wire logic DAC_ENABLE,
  input wire logic COMPARATOR_ENABLE,
  input wire logic COMP_GROUP_SELECT,
  input wire logic SAMPLE_GROUND_CONNECT,
  input wire logic MID_VOLTAGE_ENABLE,
  input wire logic SAMPLE_HOLD_ENABLE,
  input wire logic EXCITATION_ENABLE
);
  logic [1:0] up;
  logic [15:0] c2;
  logic en;
  wire logic req = AVS_READ | AVS_WRITE;
  wire logic hit = AVS_WRITE & ~AVS_WAITREQUEST;
  wire logic w1 = hit & (AVS_ADDRESS == OFS_CONTROL_ONE);
  // shadow of accepted writes; assumes the clock enable stays high
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      up <= 2'h0;
      c2 <= 16'h0000;
      en <= 1'b0;
    end else begin
      up <= {up[0], 1'b1};
      if (w1 & AVS_BYTEENABLE[0])
        en <= AVS_WRITEDATA[0];
      if (hit & (AVS_ADDRESS == OFS_CONTROL_TWO) & AVS_BYTEENABLE[0])
        c2[7:0] <= AVS_WRITEDATA[7:0];
      if (hit & (AVS_ADDRESS == OFS_CONTROL_TWO) & AVS_BYTEENABLE[1])
        c2[15:8] <= AVS_WRITEDATA[15:8];
    end
  end
  default clocking cb @(posedge SYS_CLK);
  endclocking
  // two edges of history are needed before any past value is trusted
  default disable iff (RST || !up[1]);
  property p_wait; req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
  property p_one; req && !AVS_WAITREQUEST |-> $past(req && AVS_WAITREQUEST); endproperty
  property p_dac; $past(c2[BIT_DAC_FORCE]) |-> DAC_ENABLE; endproperty
  property p_comp; $past(c2[BIT_COMP_FORCE]) |-> COMPARATOR_ENABLE; endproperty
  property p_mid; MID_VOLTAGE_ENABLE == $past(c2[BIT_MID_VOLTAGE] & ~c2[BIT_SAMPLE_HOLD]); endproperty
  property p_sh; SAMPLE_HOLD_ENABLE == $past(c2[BIT_SAMPLE_HOLD]); endproperty
  property p_exc; EXCITATION_ENABLE == $past(c2[BIT_EXCITATION]); endproperty
  property p_grp; COMP_GROUP_SELECT == $past(c2[BIT_GROUP_SELECT]); endproperty
  property p_gnd; !$past(c2[BIT_GROUND_SELECT]) |-> SAMPLE_GROUND_CONNECT; endproperty
  property p_en; SCAN_UNIT_ENABLE == $past(en); endproperty
  property p_tcr; $fell(TEST_CYCLE_REQUEST) |-> $past(TEST_CYCLE_DONE, 2) || $past(w1, 2); endproperty
  a_wait: assert property (p_wait) else $error("second wait cycle");
  a_one: assert property (p_one) else $error("answer without wait cycle");
  a_dac: assert property (p_dac) else $error("dac not forced on");
  a_comp: assert property (p_comp) else $error("comparator not forced on");
  a_mid: assert property (p_mid) else $error("mid voltage wrong");
  a_sh: assert property (p_sh) else $error("sample hold wrong");
  a_exc: assert property (p_exc) else $error("excitation wrong");
  a_grp: assert property (p_grp) else $error("group select wrong");
  a_gnd: assert property (p_gnd) else $error("ground switch open");
  a_en: assert property (p_en) else $error("unit enable wrong");
  a_tcr: assert property (p_tcr) else $error("test request dropped early");
  c_done: cover property (TEST_CYCLE_DONE && TEST_CYCLE_REQUEST);
  c_mid: cover property ($rose(MID_VOLTAGE_ENABLE));
  c_w1: cover property (w1);
endmodule
bind scnif_ctrl scnif_chk i_chk (.SYS_CLK, .RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
  .AVS_BYTEENABLE, .AVS_WAITREQUEST, .TEST_CYCLE_DONE, .TEST_CYCLE_REQUEST, .SCAN_UNIT_ENABLE,
  .DAC_ENABLE, .COMPARATOR_ENABLE, .COMP_GROUP_SELECT, .SAMPLE_GROUND_CONNECT, .MID_VOLTAGE_ENABLE,
  .SAMPLE_HOLD_ENABLE, .EXCITATION_ENABLE);
`default_nettype wire

// ===== verification/scnif_seq_model.sv
`timescale 1ns/100ps
`default_nettype none
module scnif_seq_model (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic TEST_CYCLE_REQUEST,
  output logic [7:0] FIRST_EVENT_COUNTER,
  output logic FIRST_COUNTER_STEP,
  output logic [7:0] SECOND_EVENT_COUNTER,
  output logic SECOND_COUNTER_STEP,
  output logic SEQUENCE_START,
  output logic SEQUENCER_STOP_SIGNAL,
  output logic TEST_CYCLE_DONE,
  output logic SEQ_DAC_REQUEST,
  output logic SEQ_COMP_REQUEST,
  output logic [1:0] SEQ_CHANNEL_SELECT,
  output logic SEQ_TEST_ACTIVE,
  output logic SEQ_TEST_CHANNEL,
  output logic SEQ_RESULT_STROBE,
  output logic [3:0] FRONT_END_OUTPUT_BITS,
  output logic COMPARATOR_RAW
);
  logic [3:0] k;
  // each counter reads one while its step is high and zero otherwise; modulo and wrap sources stay unused here
  assign FIRST_EVENT_COUNTER = {7'h00, FIRST_COUNTER_STEP};
  assign SECOND_EVENT_COUNTER = {7'h00, SECOND_COUNTER_STEP};
  initial begin
    {FIRST_COUNTER_STEP, SECOND_COUNTER_STEP, SEQUENCE_START} = 3'h0;
    {SEQUENCER_STOP_SIGNAL, SEQ_DAC_REQUEST, SEQ_COMP_REQUEST, SEQ_CHANNEL_SELECT} = 5'h00;
    {FRONT_END_OUTPUT_BITS, COMPARATOR_RAW, SEQ_TEST_CHANNEL} = 6'h00;
  end
  // fixed-length test cycle; a slower sequencer is not modelled
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST)
      k <= 4'h0;
    else if (k != 4'h0 || TEST_CYCLE_REQUEST)
      k <= k + 4'h1;
  end
  assign SEQ_TEST_ACTIVE = (k >= 4'h2) && (k <= 4'h6);
  assign SEQ_RESULT_STROBE = (k == 4'h4);
  assign TEST_CYCLE_DONE = (k == 4'h6);
  task automatic lev(input logic [10:0] v);
    @(posedge SYS_CLK);
    {SEQUENCER_STOP_SIGNAL, SEQ_DAC_REQUEST, SEQ_COMP_REQUEST, SEQ_CHANNEL_SELECT,
      FRONT_END_OUTPUT_BITS, COMPARATOR_RAW, SEQ_TEST_CHANNEL} <= v;
  endtask
  task automatic pulse(input logic [2:0] v);
    @(posedge SYS_CLK);
    {FIRST_COUNTER_STEP, SECOND_COUNTER_STEP, SEQUENCE_START} <= v;
    @(posedge SYS_CLK);
    {FIRST_COUNTER_STEP, SECOND_COUNTER_STEP, SEQUENCE_START} <= 3'h0;
  endtask
endmodule
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import scnif_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic CE = 1'b1;
  logic STATE_Q6_ENTRY = 1'b0;
  logic STATE_Q7_ENTRY = 1'b0;
  logic SEQ_GROUND_REQUEST = 1'b0;
  logic [3:0] AVS_ADDRESS = 4'h0;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h00000000;
  logic [3:0] AVS_BYTEENABLE = 4'h0;
  wire logic [31:0] AVS_READDATA;
  wire logic [7:0] FIRST_EVENT_COUNTER, SECOND_EVENT_COUNTER;
  wire logic [6:0] EVENT_IRQ;
  wire logic [3:0] FRONT_END_OUTPUT_BITS;
  wire logic [1:0] SEQ_CHANNEL_SELECT, COMP_INPUT_INDEX;
  wire logic AVS_WAITREQUEST, FIRST_COUNTER_STEP, SECOND_COUNTER_STEP, SEQUENCE_START;
  wire logic SEQUENCER_STOP_SIGNAL, TEST_CYCLE_DONE, SEQ_DAC_REQUEST, SEQ_COMP_REQUEST;
  wire logic SEQ_TEST_ACTIVE, SEQ_TEST_CHANNEL, SEQ_RESULT_STROBE, COMPARATOR_RAW;
  wire logic SCAN_UNIT_ENABLE, TEST_CYCLE_REQUEST, DAC_ENABLE, COMPARATOR_ENABLE;
  wire logic COMPARATOR_OUT, COMP_GROUP_SELECT, COMP_COMMON_INPUT, SAMPLE_GROUND_CONNECT;
  wire logic MID_VOLTAGE_ENABLE, SAMPLE_HOLD_ENABLE, EXCITATION_ENABLE;
  logic [15:0] fm [3] = '{16'h0020, 16'h0040, 16'h0010};
  logic [15:0] r;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  scnif_ctrl i_dut (.SYS_CLK, .RST, .CE, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
    .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .FIRST_EVENT_COUNTER, .FIRST_COUNTER_STEP,
    .SECOND_EVENT_COUNTER, .SECOND_COUNTER_STEP, .SEQUENCE_START, .SEQUENCER_STOP_SIGNAL,
    .STATE_Q6_ENTRY, .STATE_Q7_ENTRY, .TEST_CYCLE_DONE, .SEQ_DAC_REQUEST, .SEQ_COMP_REQUEST,
    .SEQ_GROUND_REQUEST, .SEQ_CHANNEL_SELECT, .SEQ_TEST_ACTIVE, .SEQ_TEST_CHANNEL, .SEQ_RESULT_STROBE,
    .FRONT_END_OUTPUT_BITS, .COMPARATOR_RAW, .SCAN_UNIT_ENABLE, .TEST_CYCLE_REQUEST, .EVENT_IRQ,
    .DAC_ENABLE, .COMPARATOR_ENABLE, .COMPARATOR_OUT, .COMP_GROUP_SELECT, .COMP_COMMON_INPUT,
    .COMP_INPUT_INDEX, .SAMPLE_GROUND_CONNECT, .MID_VOLTAGE_ENABLE, .SAMPLE_HOLD_ENABLE,
    .EXCITATION_ENABLE);
  scnif_seq_model i_seq (.SYS_CLK, .RST, .TEST_CYCLE_REQUEST, .FIRST_EVENT_COUNTER, .FIRST_COUNTER_STEP,
    .SECOND_EVENT_COUNTER, .SECOND_COUNTER_STEP, .SEQUENCE_START, .SEQUENCER_STOP_SIGNAL,
    .TEST_CYCLE_DONE, .SEQ_DAC_REQUEST, .SEQ_COMP_REQUEST, .SEQ_CHANNEL_SELECT, .SEQ_TEST_ACTIVE,
    .SEQ_TEST_CHANNEL, .SEQ_RESULT_STROBE, .FRONT_END_OUTPUT_BITS, .COMPARATOR_RAW);
  initial begin
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  task automatic complete_run();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic [6:0] g, input logic [6:0] e);
    chk_reg({9'h000, g}, {9'h000, e});
  endtask
  // the request holds until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d, input logic [3:0] b);
    @(posedge SYS_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITE <= w;
    AVS_READ <= ~w;
    AVS_WRITEDATA <= {16'h0000, d};
    AVS_BYTEENABLE <= b;
    do @(posedge SYS_CLK); while (AVS_WAITREQUEST !== 1'b0);
    r = AVS_READDATA[15:0];
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus(1'b1, a, d, 4'h3);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000, 4'h3);
    chk_reg(r, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  initial begin
    repeat (10) @(posedge SYS_CLK);
    RST <= 1'b0;
    rd(OFS_CONTROL_ONE, RST_CONTROL_ONE);
    rd(OFS_CONTROL_TWO, RST_CONTROL_TWO);
    rd(4'hC, 16'h0000);
    tend("reset");
    i_seq.pulse(3'h7);
    idle(4);
    rd(OFS_CONTROL_ONE, 16'h0000);
    wr(OFS_CONTROL_ONE, 16'hFE01);
    for (int i = 0; i < 3; i++) begin
      i_seq.pulse(3'h4 >> i);
      rd(OFS_CONTROL_ONE, 16'hFE01 | fm[i]);
      wr(OFS_CONTROL_ONE, 16'hFE01);
    end
    i_seq.lev(11'h404);
    idle(5);
    rd(OFS_CONTROL_ONE, 16'hFE0D);
    chk_pin(EVENT_IRQ, 7'h03);
    wr(OFS_CONTROL_ONE, 16'hFE01);
    idle(5);
    rd(OFS_CONTROL_ONE, 16'hFE01);
    chk_pin(EVENT_IRQ, 7'h00);
    wr(OFS_CONTROL_ONE, 16'h0205);
    idle(2);
    chk_pin(EVENT_IRQ, 7'h01);
    wr(OFS_CONTROL_ONE, 16'h0005);
    idle(2);
    chk_pin(EVENT_IRQ, 7'h00);
    fork
      wr(OFS_CONTROL_ONE, 16'h0001);
      begin
        @(posedge SYS_CLK);
        i_seq.pulse(3'h1);
      end
    join
    rd(OFS_CONTROL_ONE, 16'h0011);
    wr(OFS_CONTROL_ONE, 16'h0001);
    i_seq.lev(11'h000);
    tend("flags");
    wr(OFS_CONTROL_TWO, 16'hFFFF);
    rd(OFS_CONTROL_TWO, 16'hFFFC);
    idle(2);
    chk_pin({DAC_ENABLE, COMPARATOR_ENABLE, COMP_GROUP_SELECT, COMP_COMMON_INPUT, MID_VOLTAGE_ENABLE,
      SAMPLE_HOLD_ENABLE, EXCITATION_ENABLE}, 7'h7B);
    bus(1'b1, OFS_CONTROL_TWO, 16'h0000, 4'h1);
    rd(OFS_CONTROL_TWO, 16'hFF00);
    wr(4'hC, 16'hFFFF);
    rd(4'hC, 16'h0000);
    wr(OFS_CONTROL_TWO, 16'h0100);
    i_seq.lev(11'h300);
    idle(3);
    chk_pin({2'h0, DAC_ENABLE, COMPARATOR_ENABLE, MID_VOLTAGE_ENABLE, SAMPLE_HOLD_ENABLE,
      SAMPLE_GROUND_CONNECT}, 7'h1D);
    i_seq.lev(11'h002);
    idle(5);
    chk_pin({5'h00, DAC_ENABLE, COMPARATOR_ENABLE}, 7'h00);
    chk_pin({6'h00, COMPARATOR_OUT}, 7'h01);
    wr(OFS_CONTROL_TWO, 16'h2100);
    idle(3);
    chk_pin({6'h00, COMPARATOR_OUT}, 7'h00);
    wr(OFS_CONTROL_TWO, 16'h1400);
    idle(2);
    chk_pin({5'h00, COMP_INPUT_INDEX}, 7'h03);
    i_seq.lev(11'h082);
    wr(OFS_CONTROL_TWO, 16'h1000);
    idle(2);
    chk_pin({3'h0, COMP_GROUP_SELECT, COMP_COMMON_INPUT, COMP_INPUT_INDEX}, 7'h0A);
    wr(OFS_CONTROL_TWO, 16'h0000);
    idle(2);
    chk_pin({3'h0, COMP_GROUP_SELECT, COMP_COMMON_INPUT, COMP_INPUT_INDEX}, 7'h02);
    tend("control");
    wr(OFS_CONTROL_TWO, 16'h0024);
    for (int j = 0; j < 2; j++) begin
      i_seq.lev(j == 0 ? 11'h003 : 11'h002);
      wr(OFS_CONTROL_ONE, 16'h0003);
      @(posedge SYS_CLK iff i_seq.k == 4'h5);
      chk_pin({5'h00, COMP_INPUT_INDEX}, j == 0 ? 7'h02 : 7'h01);
      while (TEST_CYCLE_REQUEST !== 1'b0) @(posedge SYS_CLK);
      rd(OFS_CONTROL_ONE, 16'h0001);
    end
    rd(OFS_CONTROL_TWO, 16'h0027);
    tend("test cycle");
    complete_run();
  end
endmodule
`default_nettype wire
